// ---- dv/conv_core_model.sv ----
// behavioural converter core returning a channel dependent code
`timescale 1ns/1ns
module conv_core_model
  import adc_setup_pkg::*;
(
  // clock
  input  wire logic       clk,
  // control from the block
  input  wire logic       corePower,
  input  wire logic       coreSample,
  input  wire logic       coreConnect,
  input  wire logic [5:0] channelSel,
  // result
  output logic      [9:0] coreResult
);
  initial coreResult = 10'h155;
  // outside a conversion the output churns so a late sample is caught
  always @(posedge clk) begin
    if (corePower && coreSample) begin
      coreResult <= coreConnect ? {channelSel, 4'ha} : 10'h000;
    end else begin
      coreResult <= ~coreResult;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the converter setup and clocking block
`timescale 1ns/1ns
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
  import adc_setup_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        oscTick = 1'b0;
  logic        sleeping = 1'b0;
  logic        trigger = 1'b0;
  logic [7:0]  regRdata;
  logic [9:0]  coreResult;
  logic        corePower, coreSample, coreConnect;
  logic [5:0]  channelSel;
  logic [34:0] pinSelect;
  logic        selFixedRef, selDac, selTemp, selGround, negRefGround;
  logic [2:0]  posRefSel;
  logic        wakeUp, branchToIsr, irqRequest;
  logic [2:0]  irqs = 3'h0;
  int          mismatches = 0;
  int          numChecks = 0;
  int          curCh = 0;

  always #10 clk = ~clk;
  // internal oscillator half-periods arrive at an irregular rate
  always @(posedge clk) oscTick <= ($urandom % 3) == 0;

  adc_setup_and_clocking adc_setup_and_clocking_i (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .oscTick(oscTick),
    .sleeping(sleeping), .trigger(trigger), .coreResult(coreResult), .corePower(corePower),
    .coreSample(coreSample), .coreConnect(coreConnect), .channelSel(channelSel),
    .pinSelect(pinSelect), .selFixedRef(selFixedRef), .selDac(selDac), .selTemp(selTemp),
    .selGround(selGround), .posRefSel(posRefSel), .negRefGround(negRefGround),
    .wakeUp(wakeUp), .branchToIsr(branchToIsr), .irqRequest(irqRequest));

  conv_core_model conv_core_model_i (
    .clk(clk), .corePower(corePower), .coreSample(coreSample),
    .coreConnect(coreConnect), .channelSel(channelSel), .coreResult(coreResult));

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chkRd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask

  // one conversion, timed in clocks or oscillator ticks, then result and flag checks
  task automatic conv(input int div, input bit src, input bit just);
    logic [7:0] ctl;
    logic [9:0] r;
    int         n;
    int         t;
    int         e;
    ctl = 8'h80 | (src ? 8'h10 : 8'h00) | (just ? 8'h04 : 8'h00);
    wr(OFS_CLKDIV, 8'(div));
    wr(OFS_CONTROL, ctl);
    wr(OFS_CONTROL, ctl | 8'h01);
    n = 0;
    t = 0;
    #1;
    while (coreSample !== 1'b1 && t < 200) begin
      @(posedge clk);
      #1;
      t++;
    end
    while (coreSample === 1'b1 && t < 4000) begin
      n += src ? int'(oscTick) : 1;
      @(posedge clk);
      #1;
      t++;
    end
    e = src ? 23 : 23 * (div + 1);
    `CHK(n >= e - 1 && n <= e + 3, 1'b1)
    repeat (4) @(posedge clk);
    r = (curCh < 35 || curCh > 59) ? 10'({curCh[5:0], 4'ha}) : 10'h000;
    `CHK(corePower, 1'b1)
    `CHK(wakeUp, sleeping & irqs[0])
    `CHK({branchToIsr, irqRequest}, {2{irqs == 3'h7}})
    chkRd(OFS_FLAGS, 8'h01);
    chkRd(OFS_CONTROL, ctl);
    chkRd(OFS_RESULT_LO, just ? r[7:0] : {r[1:0], 6'h00});
    chkRd(OFS_RESULT_HI, just ? {6'h00, r[9:8]} : r[9:2]);
    wr(OFS_FLAGS, 8'h01);
    chkRd(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    chkRd(OFS_FLAGS, 8'h00);
  endtask

  task automatic setCh(input int c);
    curCh = c;
    wr(OFS_CHANNEL, 8'(c));
    repeat (4) @(posedge clk);
  endtask

  task final_report;
    if (mismatches == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(12));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK({corePower, negRefGround}, 2'b01)
    for (int a = 0; a < 10; a++) begin
      chkRd(4'(a), RST_BYTE);
    end
    for (int c = 0; c < 64; c++) begin
      wr(OFS_CHANNEL, 8'(c));
      #1;
      `CHK(coreConnect, 1'(c < 35 || c > 59))
      `CHK(channelSel, 6'(c))
      `CHK(pinSelect, c < 35 ? 35'h1 << c : 35'h0)
      `CHK({selFixedRef, selDac, selTemp, selGround}, {c == 63, c == 62, c == 61, c == 60})
    end
    for (int i = 0; i < 8; i++) begin
      regWdata <= 8'h00;
      wr(OFS_REFERENCE, 8'(i) | (8'($urandom) & 8'h10));
      #1;
      `CHK(posRefSel, 3'(i))
      `CHK(negRefGround, ~regWdata[4])
    end
    setCh(5);
    conv(0, 1'b0, 1'b1);
    setCh(int'(CH_GROUND));
    conv($urandom % 4, 1'b0, 1'b0);
    setCh($urandom % 35);
    conv(63, 1'b0, 1'b1);
    setCh(40);
    conv(1, 1'b0, 1'b0);
    @(posedge clk);
    sleeping <= 1'b1;
    wr(OFS_CONTROL, 8'h81);
    repeat (30) @(posedge clk);
    `CHK(coreSample, 1'b0)
    wr(OFS_CONTROL, 8'h80);
    irqs = 3'h3;
    wr(OFS_IRQCTL, 8'h03);
    setCh(int'(CH_DAC));
    conv(0, 1'b1, 1'b0);
    irqs = 3'h7;
    wr(OFS_IRQCTL, 8'h07);
    conv(2, 1'b1, 1'b1);
    @(posedge clk);
    sleeping <= 1'b0;
    wr(OFS_CONTROL, 8'hc1);
    repeat (100) @(posedge clk);
    chkRd(OFS_CONTROL, 8'hc1);
    chkRd(OFS_FLAGS, 8'h01);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_FLAGS, 8'h00);
    trigger <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(coreSample, 1'b1)
    wr(OFS_CONTROL, 8'h00);
    trigger <= 1'b0;
    wr(OFS_CONTROL, 8'h01);
    chkRd(OFS_CONTROL, 8'h00);
    `CHK(corePower, 1'b0)
    final_report();
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule

// ---- rtl/adc_setup_and_clocking.sv ----
// converter setup, clock selection, conversion timing, done flag and result formatting
// Contract
// - channel field routes pin codes, ground, temperature, DAC or fixed reference to sampler
// - reserved channel codes connect nothing to the sampler
// - positive reference chooses pin, supply or fixed reference at three levels
// - one bit selects negative reference pin or analog ground
// - source bit one picks internal oscillator, zero picks divided system clock
// - divider field gives even ratios from two up to one hundred twenty-eight
// - a conversion lasts eleven and a half conversion clock periods
// - control runs on selected clock; internal oscillator adds synchronisation delay
// - done flag sets after every conversion regardless of interrupt enable
// - converter runs in sleep only from the internal oscillator
// - done interrupt during sleep wakes the device to the next instruction
// - with all three enables set wake branches to handler, else in line
// - justify bit presents result left or right in the register pair
// - module powered only while on; go by software or trigger starts
// - at completion go clears unless continuous, and done flag sets
`timescale 1ns/1ns
module adc_setup_and_clocking
  import adc_setup_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // internal oscillator, already synchronous
  input  wire logic        oscTick,
  // system state
  input  wire logic        sleeping,
  input  wire logic        trigger,
  // converter core
  input  wire logic [9:0]  coreResult,
  output logic             corePower,
  output logic             coreSample,
  output logic             coreConnect,
  output logic      [5:0]  channelSel,
  output logic      [34:0] pinSelect,
  output logic             selFixedRef,
  output logic             selDac,
  output logic             selTemp,
  output logic             selGround,
  output logic      [2:0]  posRefSel,
  output logic             negRefGround,
  // wake and interrupt
  output logic             wakeUp,
  output logic             branchToIsr,
  output logic             irqRequest
);
  // control registers
  logic       on_q;
  logic       cont_q;
  logic       src_q;
  logic       just_q;
  logic       go_q;
  logic [5:0] chan_q;
  logic [2:0] pref_q;
  logic       nref_q;
  logic [5:0] div_q;
  logic       done_q;
  logic       ieConv_q;
  logic       iePeri_q;
  logic       ieGlob_q;
  logic [9:0] result_q;
  logic [7:0] rdata_q;
  logic       trigPrev_q;
  logic [SYNC_STAGES-1:0] goSync_q;

  // decoded strobes
  wire wrCtl   = regWrite && (regAddr == OFS_CONTROL);
  wire wrChan  = regWrite && (regAddr == OFS_CHANNEL);
  wire wrRef   = regWrite && (regAddr == OFS_REFERENCE);
  wire wrDiv   = regWrite && (regAddr == OFS_CLKDIV);
  wire wrFlag  = regWrite && (regAddr == OFS_FLAGS);
  wire wrIrq   = regWrite && (regAddr == OFS_IRQCTL);

  // clock selection: divided system clock or internal oscillator half-periods
  logic divTick;
  // without the internal oscillator the core is frozen in sleep
  wire  mayRun   = on_q && (src_q || !sleeping);
  // the divider restarts whenever go rises and stays in step in continuous mode, so a conversion spans exactly 23 half-periods
  wire  runDiv   = go_q && mayRun && !src_q;
  wire  oscAllow = on_q && src_q;
  wire  convTick = src_q ? (oscTick && oscAllow) : divTick;

  conv_clock_divider u_div (
    .clk      (clk),
    .reset    (reset),
    .divSel   (div_q),
    .run      (runDiv),
    .halfTick (divTick)
  );

  // go seen by the conversion logic: delayed through the oscillator domain stages when selected
  wire goSeen = src_q ? goSync_q[SYNC_STAGES-1] : go_q;
  wire active = goSeen && go_q && mayRun;

  logic lastTick;
  conv_sequencer u_seq (
    .clk      (clk),
    .reset    (reset),
    .tick     (convTick),
    .active   (active),
    .lastTick (lastTick)
  );

  wire trigEdge = trigger && !trigPrev_q;

  // synchronisation delay for the go bit on the internal oscillator, stepped at its rate
  always_ff @(posedge clk) begin
    if (reset || !go_q) begin
      goSync_q <= '0;
    end else if (oscTick) begin
      goSync_q <= {goSync_q[SYNC_STAGES-2:0], 1'b1};
    end
  end

  // control register: go set by software or trigger edge, cleared at the end unless continuous
  always_ff @(posedge clk) begin
    if (reset) begin
      {on_q, cont_q, src_q, just_q} <= 4'h0;
      go_q       <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigger;
      if (wrCtl) begin
        on_q   <= regWdata[CTL_ON_BIT];
        cont_q <= regWdata[CTL_CONT_BIT];
        src_q  <= regWdata[CTL_SRC_BIT];
        just_q <= regWdata[CTL_JUST_BIT];
      end
      if (lastTick && !cont_q) begin
        go_q <= 1'b0;
      end else if ((wrCtl && regWdata[CTL_GO_BIT] && on_q) || (trigEdge && on_q)) begin
        go_q <= 1'b1;
      end else if (wrCtl && !regWdata[CTL_GO_BIT]) begin
        go_q <= 1'b0;
      end else if (!on_q) begin
        go_q <= 1'b0;
      end
    end
  end

  // setup registers, cleared by reset
  always_ff @(posedge clk) begin
    if (reset) begin
      chan_q <= RST_BYTE[5:0];
      pref_q <= RST_BYTE[2:0];
      nref_q <= 1'b0;
      div_q  <= RST_BYTE[5:0];
      {ieGlob_q, iePeri_q, ieConv_q} <= 3'h0;
    end else begin
      if (wrChan) chan_q <= regWdata[5:0];
      if (wrRef) begin
        pref_q <= regWdata[2:0];
        nref_q <= regWdata[REF_NEG_BIT];
      end
      if (wrDiv) div_q <= regWdata[5:0];
      if (wrIrq) begin
        ieConv_q <= regWdata[IRQ_CONV_BIT];
        iePeri_q <= regWdata[IRQ_PERI_BIT];
        ieGlob_q <= regWdata[IRQ_GLOB_BIT];
      end
    end
  end

  // done flag: hardware only sets; the set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (lastTick) begin
      done_q <= 1'b1;
    end else if (wrFlag && !regWdata[FLG_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // result capture; an aborted conversion leaves the old value
  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= '0;
    end else if (lastTick) begin
      result_q <= coreResult;
    end
  end

  // justified result pair
  wire [15:0] resultPair = just_q ? {6'h00, result_q} : {result_q, 6'h00};

  // read mux
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      OFS_CONTROL:   rdMux = {on_q, cont_q, 1'b0, src_q, 1'b0, just_q, 1'b0, go_q};
      OFS_CHANNEL:   rdMux = {2'h0, chan_q};
      OFS_REFERENCE: rdMux = {3'h0, nref_q, 1'b0, pref_q};
      OFS_CLKDIV:    rdMux = {2'h0, div_q};
      OFS_FLAGS:     rdMux = {7'h00, done_q};
      OFS_RESULT_LO: rdMux = resultPair[7:0];
      OFS_RESULT_HI: rdMux = resultPair[15:8];
      OFS_IRQCTL:    rdMux = {5'h00, ieGlob_q, iePeri_q, ieConv_q};
      default:       rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) rdata_q <= 8'h00;
    else if (regRead) rdata_q <= rdMux;
    else rdata_q <= 8'h00;
  end
  assign regRdata = rdata_q;

  // channel routing
  wire reservedCh = (chan_q > CH_PIN_LAST) && (chan_q < CH_GROUND);
  assign selFixedRef = (chan_q == CH_FIXED_REF);
  assign selDac      = (chan_q == CH_DAC);
  assign selTemp     = (chan_q == CH_TEMP);
  assign selGround   = (chan_q == CH_GROUND);
  assign coreConnect = !reservedCh;
  assign channelSel  = chan_q;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign pinSelect[gi] = (chan_q == 6'(gi));
    end
  endgenerate

  // reference selection
  assign posRefSel    = pref_q;
  assign negRefGround = !nref_q;

  // power, sampling and wake
  assign corePower   = on_q;
  assign coreSample  = active;
  wire   irqArmed    = done_q && ieConv_q;
  assign wakeUp      = sleeping && irqArmed;
  assign branchToIsr = irqArmed && iePeri_q && ieGlob_q;
  assign irqRequest  = branchToIsr;

  done_sets_a: assert property (@(posedge clk) disable iff (reset)
    lastTick |=> done_q)
    else $error("done flag not set");
  done_sticky_a: assert property (@(posedge clk) disable iff (reset)
    (done_q && !(wrFlag && !regWdata[FLG_DONE_BIT])) |=> done_q)
    else $error("done flag cleared by hardware");
  go_clear_a: assert property (@(posedge clk) disable iff (reset)
    (lastTick && !cont_q) |=> !go_q)
    else $error("go not cleared");
  go_cont_a: assert property (@(posedge clk) disable iff (reset)
    (lastTick && cont_q && !wrCtl && on_q) |=> go_q)
    else $error("continuous go dropped");
  reserved_open_a: assert property (@(posedge clk) disable iff (reset)
    (chan_q >= 6'h23 && chan_q <= 6'h3b) |-> !coreConnect && pinSelect == '0)
    else $error("reserved channel connected");
  sleep_hold_a: assert property (@(posedge clk) disable iff (reset)
    (sleeping && !src_q) |-> !coreSample)
    else $error("converting in sleep without oscillator");
  justify_a: assert property (@(posedge clk) disable iff (reset)
    just_q |-> resultPair[15:10] == 6'h00 && resultPair[9:0] == result_q)
    else $error("right justify wrong");
  wake_isr_a: assert property (@(posedge clk) disable iff (reset)
    (sleeping && done_q && ieConv_q) |-> wakeUp && (branchToIsr == (iePeri_q && ieGlob_q)))
    else $error("wake or branch wrong");
  read_late_a: assert property (@(posedge clk) disable iff (reset)
    (regRead && regAddr == OFS_CLKDIV) |=> regRdata == {2'h0, $past(div_q)})
    else $error("read data wrong");

  // go and flag checks
  go_needs_on_a: assert property (@(posedge clk) disable iff (reset)
    !on_q |=> !go_q)
    else $error("go set while off");
  trig_start_a: assert property (@(posedge clk) disable iff (reset)
    (trigEdge && on_q && !(lastTick && !cont_q)) |=> go_q)
    else $error("trigger did not start");
  go_abort_a: assert property (@(posedge clk) disable iff (reset)
    (wrCtl && !regWdata[CTL_GO_BIT] && !trigEdge) |=> !go_q)
    else $error("go not cleared by write");
  done_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wrFlag && !regWdata[FLG_DONE_BIT] && !lastTick) |=> !done_q)
    else $error("done flag not cleared");
  sync_delay_a: assert property (@(posedge clk) disable iff (reset)
    (src_q && $rose(go_q)) |-> !coreSample)
    else $error("oscillator start not delayed");
  // routing and format checks
  pin_onehot_a: assert property (@(posedge clk) disable iff (reset)
    (chan_q <= CH_PIN_LAST) |-> $onehot(pinSelect) && coreConnect)
    else $error("pin select not one-hot");
  ground_route_a: assert property (@(posedge clk) disable iff (reset)
    (chan_q == CH_GROUND) |-> selGround && coreConnect && pinSelect == '0 && !selDac && !selTemp)
    else $error("ground channel misrouted");
  justify_left_a: assert property (@(posedge clk) disable iff (reset)
    !just_q |-> resultPair[5:0] == 6'h00 && resultPair[15:6] == result_q)
    else $error("left justify wrong");
endmodule

// ---- rtl/adc_setup_pkg.sv ----
// shared constants for the converter setup and clocking block
package adc_setup_pkg;
  // channel select codes
  localparam logic [5:0] CH_FIXED_REF    = 6'h3f;
  localparam logic [5:0] CH_DAC          = 6'h3e;
  localparam logic [5:0] CH_TEMP         = 6'h3d;
  localparam logic [5:0] CH_GROUND       = 6'h3c;
  localparam logic [5:0] CH_PIN_LAST     = 6'h22;
  localparam int         PIN_COUNT       = 35;
  // register offsets
  localparam logic [3:0] OFS_CONTROL     = 4'h0;
  localparam logic [3:0] OFS_CHANNEL     = 4'h1;
  localparam logic [3:0] OFS_REFERENCE   = 4'h2;
  localparam logic [3:0] OFS_CLKDIV      = 4'h3;
  localparam logic [3:0] OFS_FLAGS       = 4'h4;
  localparam logic [3:0] OFS_RESULT_LO   = 4'h5;
  localparam logic [3:0] OFS_RESULT_HI   = 4'h6;
  localparam logic [3:0] OFS_IRQCTL      = 4'h7;
  // control field positions
  localparam int         CTL_ON_BIT      = 7;
  localparam int         CTL_CONT_BIT    = 6;
  localparam int         CTL_SRC_BIT     = 4;
  localparam int         CTL_JUST_BIT    = 2;
  localparam int         CTL_GO_BIT      = 0;
  // flag / irq field positions
  localparam int         FLG_DONE_BIT    = 0;
  localparam int         IRQ_CONV_BIT    = 0;
  localparam int         IRQ_PERI_BIT    = 1;
  localparam int         IRQ_GLOB_BIT    = 2;
  // reference field positions
  localparam int         REF_NEG_BIT     = 4;
  localparam logic [2:0] PREF_SUPPLY     = 3'h0;
  localparam logic [2:0] PREF_PIN        = 3'h2;
  localparam logic [2:0] PREF_FVR1       = 3'h4;
  localparam logic [2:0] PREF_FVR2       = 3'h5;
  localparam logic [2:0] PREF_FVR4       = 3'h6;
  // reset values
  localparam logic [7:0] RST_BYTE        = 8'h00;
  // timing: a conversion is 23 half-periods (11.5 periods)
  localparam int         CONV_HALF_TAD   = 23;
  localparam int         SYNC_STAGES     = 2;
  localparam int         RESULT_BITS     = 10;
endpackage

// ---- rtl/conv_clock_divider.sv ----
// even-ratio divider producing half-period enables of the conversion clock
`timescale 1ns/1ns
module conv_clock_divider
  import adc_setup_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // setting
  input  wire logic [5:0] divSel,
  input  wire logic       run,
  // half-period enable
  output logic            halfTick
);
  logic [5:0] count_q;
  wire        atEnd = (count_q == 6'h00);

  // the divider reloads its field only at a boundary, so a change never makes a short half-period
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      count_q <= divSel;
    end else if (atEnd) begin
      count_q <= divSel;
    end else begin
      count_q <= count_q - 6'h01;
    end
  end

  assign halfTick = run && atEnd; // half-period = divSel+1 clocks, period = 2*(divSel+1)

  divider_period_a: assert property (@(posedge clk) disable iff (reset)
    (halfTick && run && $stable(divSel)) |=> (!halfTick [*1]) or (divSel == 6'h00))
    else $error("divider tick too early");
endmodule

// ---- rtl/conv_sequencer.sv ----
// counts the 11.5 conversion clock periods of one conversion
`timescale 1ns/1ns
module conv_sequencer
  import adc_setup_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // timing
  input  wire logic tick,
  input  wire logic active,
  // completion
  output logic      lastTick
);
  logic [4:0] halves_q;
  wire        atLast = (halves_q == 5'(CONV_HALF_TAD - 1));

  // restart whenever the conversion is idle or aborted
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      halves_q <= 5'h00;
    end else if (tick) begin
      halves_q <= atLast ? 5'h00 : halves_q + 5'h01;
    end
  end

  assign lastTick = active && tick && atLast;

  seq_count_a: assert property (@(posedge clk) disable iff (reset)
    lastTick |-> $past(halves_q) == 5'(CONV_HALF_TAD - 1) || halves_q == 5'(CONV_HALF_TAD - 1))
    else $error("conversion ended at wrong count");
endmodule
